// >>> csr_lite_pkg.sv
package csr_lite_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int PROT_W = 3;
   localparam int RESP_W = 2;
   localparam int NUM_REGS = 32;
   localparam int IDX_W = 5;
   localparam int IDX_LSB = 2;
   localparam logic [RESP_W-1:0] RESP_OKAY = 2'h0;
   localparam logic [RESP_W-1:0] RESP_EXOKAY = 2'h1;
   localparam logic [RESP_W-1:0] RESP_SLVERR = 2'h2;
   localparam logic [RESP_W-1:0] RESP_DECERR = 2'h3;
   localparam logic [DATA_W-1:0] REG_RESET_VAL = 32'h0;
endpackage

// >>> csr_lite_if.sv
`timescale 1ns/1ns
interface csr_lite_if;
   import csr_lite_pkg::*;
   logic [ADDR_W-1:0] awaddr;
   logic [PROT_W-1:0] awprot;
   logic awvalid;
   logic awready;
   logic [DATA_W-1:0] wdata;
   logic [STRB_W-1:0] wstrb;
   logic wvalid;
   logic wready;
   logic [RESP_W-1:0] bresp;
   logic bvalid;
   logic bready;
   logic [ADDR_W-1:0] araddr;
   logic [PROT_W-1:0] arprot;
   logic arvalid;
   logic arready;
   logic [DATA_W-1:0] rdata;
   logic [RESP_W-1:0] rresp;
   logic rvalid;
   logic rready;
   modport slave (
      input awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
      input araddr, arprot, arvalid, rready,
      output awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
   );
   modport master (
      output awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready,
      output araddr, arprot, arvalid, rready,
      input awready, wready, bresp, bvalid, arready, rdata, rresp, rvalid
   );
endinterface

// >>> mixer_csr_lite_slave.sv
// Operation
// - Raise awready, capture address on handshake.
// - Write 32-bit data to addressed register.
// - Master holds write data until wready.
// - Four strobes enable byte lanes, bit0 lowest.
// - No data accepted before address captured.
// - Write response codes on bresp.
// - Master raises bready when able.
// - Hold bvalid and bresp until bready.
// - Master holds 7-bit read address until arready.
// - Read protection bits are ignored.
// - Master holds arvalid past arready edge.
// - Raise arready, capture read address on handshake.
// - Return addressed register contents on rdata.
// - Read response codes on rresp.
// - Hold rvalid, rdata, rresp until rready.
// - Master raises rready when able.
// - Active-low reset restores register contents.
// - Master holds awvalid and address past awready.
// - Write protection bits are ignored.
`timescale 1ns/1ns
module mixer_csr_lite_slave (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   csr_lite_if.slave bus,
   output logic [csr_lite_pkg::DATA_W*csr_lite_pkg::NUM_REGS-1:0] o_ctrl_regs
);
   import csr_lite_pkg::*;

   logic [DATA_W-1:0] regs_q [NUM_REGS];
   logic aw_have_q;
   logic [IDX_W-1:0] aw_idx_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic arready_q;
   logic rvalid_q;
   logic [DATA_W-1:0] rdata_q;
   logic [RESP_W-1:0] bresp_q;
   logic [RESP_W-1:0] rresp_q;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;

   function automatic logic [IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
      reg_index = a[IDX_LSB +: IDX_W];
   endfunction

   // Lanes whose strobe is low keep their old byte, so a narrow write never disturbs
   // the neighbouring fields of the same word.
   function automatic logic [DATA_W-1:0] merge_lanes(
      input logic [DATA_W-1:0] old_word,
      input logic [DATA_W-1:0] new_word,
      input logic [STRB_W-1:0] strb
   );
      merge_lanes = old_word;
      for (int b = 0; b < STRB_W; b++) begin
         if (strb[b]) begin
            merge_lanes[8*b +: 8] = new_word[8*b +: 8];
         end
      end
   endfunction

   // The protection attributes are never read, so they cannot alter any result.
   // One write and one read are in flight at a time; that keeps the bank simple at the
   // cost of bus throughput, which a control port does not need.
   assign aw_hs = bus.awvalid && awready_q;
   assign w_hs = bus.wvalid && wready_q;
   assign ar_hs = bus.arvalid && arready_q;

   assign bus.awready = awready_q;
   assign bus.wready = wready_q;
   assign bus.bvalid = bvalid_q;
   assign bus.bresp = bresp_q;
   assign bus.arready = arready_q;
   assign bus.rvalid = rvalid_q;
   assign bus.rdata = rdata_q;
   assign bus.rresp = rresp_q;

   // Address ready stays low from capture until the response is taken.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         awready_q <= 1'b0;
      end else if (aw_hs) begin
         awready_q <= 1'b0;
      end else if (bvalid_q && bus.bready) begin
         awready_q <= 1'b1;
      end else if (!aw_have_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         aw_have_q <= 1'b0;
      end else if (aw_hs) begin
         aw_have_q <= 1'b1;
      end else if (bvalid_q && bus.bready) begin
         aw_have_q <= 1'b0;
      end
   end

   // Only the word index is kept; the byte offset is dropped, so an unaligned address
   // selects the word that holds it.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         aw_idx_q <= '0;
      end else if (aw_hs) begin
         aw_idx_q <= reg_index(bus.awaddr);
      end
   end

   // Data ready only after the address is held, which costs a cycle but never
   // lets data commit without a target.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         wready_q <= 1'b0;
      end else if (w_hs) begin
         wready_q <= 1'b0;
      end else begin
         wready_q <= aw_have_q && !bvalid_q;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         bvalid_q <= 1'b0;
      end else if (w_hs) begin
         bvalid_q <= 1'b1;
      end else if (bus.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Every word of the bank exists and is writable, so no write can fail; the code is
   // still registered so that it stands with the response valid.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         bresp_q <= RESP_OKAY;
      end else if (w_hs) begin
         bresp_q <= RESP_OKAY;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= REG_RESET_VAL;
         end
      end else if (w_hs) begin
         regs_q[aw_idx_q] <= merge_lanes(regs_q[aw_idx_q], bus.wdata, bus.wstrb);
      end
   end

   // A new read address is refused until the previous data has been handed over, and for
   // one cycle more, since ready is rebuilt from the registered valid.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         arready_q <= 1'b0;
      end else if (ar_hs) begin
         arready_q <= 1'b0;
      end else begin
         arready_q <= !rvalid_q;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         rvalid_q <= 1'b0;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
      end else if (rvalid_q && bus.rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Read data is captured once at the address handshake and then held, so it cannot
   // follow a later write to the same word while the master is not yet ready.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         rdata_q <= '0;
      end else if (ar_hs) begin
         rdata_q <= regs_q[reg_index(bus.araddr)];
      end
   end

   // Every read hits a word of the bank, so the read code is always a success.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         rresp_q <= RESP_OKAY;
      end else if (ar_hs) begin
         rresp_q <= RESP_OKAY;
      end
   end

   // The bank is copied out through a register stage, so the mixer sees a change one
   // cycle after the write lands.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         o_ctrl_regs <= '0;
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            o_ctrl_regs[i*DATA_W +: DATA_W] <= regs_q[i];
         end
      end
   end
endmodule

// >>> csr_lite_master.sv
`timescale 1ns/1ns
module csr_lite_master (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   csr_lite_if.master bus,
   input wire logic i_wr_req,
   input wire logic [csr_lite_pkg::ADDR_W-1:0] i_wr_addr,
   input wire logic [csr_lite_pkg::DATA_W-1:0] i_wr_data,
   input wire logic [csr_lite_pkg::STRB_W-1:0] i_wr_strb,
   output logic o_wr_busy,
   output logic o_wr_done,
   output logic [csr_lite_pkg::RESP_W-1:0] o_wr_resp,
   input wire logic i_rd_req,
   input wire logic [csr_lite_pkg::ADDR_W-1:0] i_rd_addr,
   output logic o_rd_busy,
   output logic o_rd_done,
   output logic [csr_lite_pkg::DATA_W-1:0] o_rd_data,
   output logic [csr_lite_pkg::RESP_W-1:0] o_rd_resp
);
   import csr_lite_pkg::*;

   logic awvalid_q;
   logic wvalid_q;
   logic bready_q;
   logic arvalid_q;
   logic rready_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [STRB_W-1:0] wstrb_q;
   logic [ADDR_W-1:0] araddr_q;

   assign bus.awaddr = awaddr_q;
   // The bank gives the attribute no meaning, so any pattern is legal here.
   assign bus.awprot = awaddr_q[PROT_W-1:0];
   assign bus.awvalid = awvalid_q;
   assign bus.wdata = wdata_q;
   assign bus.wstrb = wstrb_q;
   assign bus.wvalid = wvalid_q;
   assign bus.bready = bready_q;
   assign bus.araddr = araddr_q;
   assign bus.arprot = araddr_q[PROT_W-1:0];
   assign bus.arvalid = arvalid_q;
   assign bus.rready = rready_q;

   // Address, data and strobes are held in registers until their handshakes.
   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         awvalid_q <= 1'b0;
         wvalid_q <= 1'b0;
         bready_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         o_wr_busy <= 1'b0;
         o_wr_done <= 1'b0;
         o_wr_resp <= RESP_OKAY;
      end else begin
         o_wr_done <= 1'b0;
         if (!o_wr_busy && i_wr_req) begin
            awvalid_q <= 1'b1;
            wvalid_q <= 1'b1;
            awaddr_q <= i_wr_addr;
            wdata_q <= i_wr_data;
            wstrb_q <= i_wr_strb;
            o_wr_busy <= 1'b1;
         end else begin
            if (awvalid_q && bus.awready) begin
               awvalid_q <= 1'b0;
            end
            if (wvalid_q && bus.wready) begin
               wvalid_q <= 1'b0;
            end
            // Ready follows the response by one cycle: this costs a cycle per transfer,
            // but the slave must then hold every response it raises.
            if (bus.bvalid && !bready_q) begin
               bready_q <= 1'b1;
            end
            if (bready_q && bus.bvalid) begin
               bready_q <= 1'b0;
               o_wr_busy <= 1'b0;
               o_wr_done <= 1'b1;
               o_wr_resp <= bus.bresp;
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         arvalid_q <= 1'b0;
         rready_q <= 1'b0;
         araddr_q <= '0;
         o_rd_busy <= 1'b0;
         o_rd_done <= 1'b0;
         o_rd_data <= '0;
         o_rd_resp <= RESP_OKAY;
      end else begin
         o_rd_done <= 1'b0;
         if (!o_rd_busy && i_rd_req) begin
            arvalid_q <= 1'b1;
            araddr_q <= i_rd_addr;
            o_rd_busy <= 1'b1;
         end else begin
            if (arvalid_q && bus.arready) begin
               arvalid_q <= 1'b0;
            end
            if (bus.rvalid && !rready_q) begin
               rready_q <= 1'b1;
            end
            if (rready_q && bus.rvalid) begin
               rready_q <= 1'b0;
               o_rd_busy <= 1'b0;
               o_rd_done <= 1'b1;
               o_rd_data <= bus.rdata;
               o_rd_resp <= bus.rresp;
            end
         end
      end
   end
endmodule

// >>> csr_lite_assertions.sv
`timescale 1ns/1ns
module csr_lite_assertions (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [csr_lite_pkg::RESP_W-1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [csr_lite_pkg::DATA_W-1:0] rdata,
   input wire logic [csr_lite_pkg::RESP_W-1:0] rresp,
   input wire logic rvalid,
   input wire logic rready
);
   import csr_lite_pkg::*;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   sequence s_aw_hs; awvalid && awready; endsequence
   sequence s_w_hs; wvalid && wready; endsequence
   property p_aw_take; s_aw_hs |=> !awready ##1 wready; endproperty
   a_aw_take: assert property (p_aw_take) else $error("aw not taken");
   property p_w_need_aw; wready |-> !awready && !bvalid; endproperty
   a_w_need_aw: assert property (p_w_need_aw) else $error("w without aw");
   property p_b_resp; s_w_hs |=> bvalid && bresp == RESP_OKAY; endproperty
   a_b_resp: assert property (p_b_resp) else $error("no write response");
   property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   property p_aw_back; bvalid && bready |-> ##[1:2] awready; endproperty
   a_aw_back: assert property (p_aw_back) else $error("awready lost");
   property p_ar_take; arvalid && arready |=> rvalid && !arready; endproperty
   a_ar_take: assert property (p_ar_take) else $error("read not answered");
   property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   property p_r_resp; rvalid |-> rresp == RESP_OKAY; endproperty
   a_r_resp: assert property (p_r_resp) else $error("bad read response");
   property p_ar_back; rvalid && rready |-> ##[1:2] arready; endproperty
   a_ar_back: assert property (p_ar_back) else $error("arready lost");
endmodule

// >>> tb.sv
`timescale 1ns/1ns
module tb;
   import csr_lite_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic wr_req = 1'b0;
   logic rd_req = 1'b0;
   logic [ADDR_W-1:0] wr_addr = '0;
   logic [ADDR_W-1:0] rd_addr = '0;
   logic [DATA_W-1:0] wr_data = '0;
   logic [STRB_W-1:0] wr_strb = '0;
   logic wr_busy, wr_done, rd_busy, rd_done;
   logic [RESP_W-1:0] wr_resp, rd_resp;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W*NUM_REGS-1:0] regs;
   logic [DATA_W-1:0] model [NUM_REGS];
   logic [DATA_W-1:0] q_rd [$];
   logic [RESP_W-1:0] q_wr [$];
   int n_mismatch = 0;
   int n_compared = 0;
   csr_lite_if bus ();
   mixer_csr_lite_slave mixer_csr_lite_slave_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .bus(bus), .o_ctrl_regs(regs));
   csr_lite_master csr_lite_master_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .bus(bus),
      .i_wr_req(wr_req), .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_wr_strb(wr_strb),
      .o_wr_busy(wr_busy), .o_wr_done(wr_done), .o_wr_resp(wr_resp), .i_rd_req(rd_req),
      .i_rd_addr(rd_addr), .o_rd_busy(rd_busy), .o_rd_done(rd_done), .o_rd_data(rd_data),
      .o_rd_resp(rd_resp));
   csr_lite_assertions csr_lite_assertions_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
      .awvalid(bus.awvalid), .awready(bus.awready), .wvalid(bus.wvalid), .wready(bus.wready),
      .bresp(bus.bresp), .bvalid(bus.bvalid), .bready(bus.bready), .arvalid(bus.arvalid),
      .arready(bus.arready), .rdata(bus.rdata), .rresp(bus.rresp), .rvalid(bus.rvalid),
      .rready(bus.rready));
   initial begin
      forever #4 i_core_clk = ~i_core_clk;
   end
   task automatic summarize();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // A bounded wait; a hang is counted and ends the run.
   task automatic wait_for(ref logic s, input logic v);
      int k;
      k = 0;
      while (s !== v) begin
         @(posedge i_core_clk);
         #1;
         k++;
         if (k > 100) begin
            n_mismatch++;
            summarize();
         end
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [STRB_W-1:0] s);
      wait_for(wr_busy, 1'b0);
      for (int b = 0; b < STRB_W; b++) begin
         if (s[b]) model[a[IDX_LSB+:IDX_W]][8*b+:8] = d[8*b+:8];
      end
      q_wr.push_back(RESP_OKAY);
      {wr_addr, wr_data, wr_strb, wr_req} = {a, d, s, 1'b1};
      @(posedge i_core_clk);
      #1 wr_req = 1'b0;
      wait_for(wr_done, 1'b1);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      wait_for(rd_busy, 1'b0);
      q_rd.push_back(model[a[IDX_LSB+:IDX_W]]);
      {rd_addr, rd_req} = {a, 1'b1};
      @(posedge i_core_clk);
      #1 rd_req = 1'b0;
      wait_for(rd_done, 1'b1);
   endtask
   task automatic rd_all();
      for (int i = 0; i < NUM_REGS; i++) rd(ADDR_W'(4 * i + ($urandom % 4)));
   endtask
   always @(posedge i_core_clk) begin
      if (wr_done === 1'b1) chk("wr_resp", 32'(wr_resp), 32'(q_wr.pop_front()));
      if (rd_done === 1'b1) chk("rd_data", rd_data, q_rd.pop_front());
      if (rd_done === 1'b1) chk("rd_resp", 32'(rd_resp), 32'(RESP_OKAY));
   end
   initial begin
      logic [ADDR_W-1:0] a;
      void'($urandom(12));
      foreach (model[i]) model[i] = REG_RESET_VAL;
      repeat (3) @(posedge i_core_clk);
      #1 i_nrst = 1'b1;
      rd_all();
      for (int i = 0; i < 80; i++) begin
         a = ADDR_W'($urandom);
         // The read targets the other half, so its expectation cannot race the write.
         fork
            wr(a, $urandom, STRB_W'($urandom));
            rd(a ^ 7'h40);
         join
      end
      rd_all();
      repeat (2) @(posedge i_core_clk);
      #1;
      for (int i = 0; i < NUM_REGS; i++) chk("ctrl_regs", regs[DATA_W*i+:DATA_W], model[i]);
      i_nrst = 1'b0;
      repeat (2) @(posedge i_core_clk);
      #1 i_nrst = 1'b1;
      foreach (model[i]) model[i] = REG_RESET_VAL;
      rd_all();
      summarize();
   end
endmodule
